// ==== rtl/ssq_consts.svh ====
// Purpose: Constants for the soft-start, output-ok and switching clock sequencer.
// Assumes: A 100 MHz core clock.
// Notes: Times are kept in their own unit and turned into counts by expressions.
`ifndef SSQ_CONSTS_SVH
`define SSQ_CONSTS_SVH

`define SSQ_CLK_NS 10
`define SSQ_US_NS 1000
`define SSQ_US_CYC (`SSQ_US_NS / `SSQ_CLK_NS)
`define SSQ_MS_US 1000
`define SSQ_INIT_MS 10
`define SSQ_PRERAMP_MS 2
`define SSQ_AUTOCOMP_MS 5
`define SSQ_SS_MS0 2
`define SSQ_SS_MS1 5
`define SSQ_SS_MS2 10
`define SSQ_SS_MS3 20
`define SSQ_PG_LO_PCT 10
`define SSQ_PG_HI_PCT 15
`define SSQ_PCT_FULL 100
`define SSQ_OSC_KHZ 400
`define SSQ_OSC_PERIOD_CYC (1000000 / (`SSQ_OSC_KHZ * `SSQ_CLK_NS))
`define SSQ_SYNC_MIN_KHZ 200
`define SSQ_SYNC_WAIT_CYC (2 * 1000000 / (`SSQ_SYNC_MIN_KHZ * `SSQ_CLK_NS))

`define SSQ_OFS_CTRL 8'h00
`define SSQ_OFS_DELAY 8'h04
`define SSQ_OFS_RAMP 8'h08
`define SSQ_OFS_PGDLY 8'h0C
`define SSQ_OFS_TARGET 8'h10
`define SSQ_OFS_WINDOW 8'h14
`define SSQ_OFS_OSC 8'h18
`define SSQ_OFS_STATUS 8'h1C
`define SSQ_OFS_EFFDLY 8'h20
`define SSQ_OFS_EFFRAMP 8'h24
`define SSQ_OFS_MEAS 8'h28

`define SSQ_CTRL_DLY_OVR 0
`define SSQ_CTRL_RAMP_OVR 1
`define SSQ_CTRL_PGDLY_OVR 2
`define SSQ_CTRL_PG_INV 3
`define SSQ_CTRL_AUTOCOMP 4
`define SSQ_CTRL_CLK_IN 5
`define SSQ_CTRL_RESTORE 6
`define SSQ_CTRL_RST 7'h00
`define SSQ_TARGET_RST 12'h000

`endif

// ==== rtl/ssq_pkg.sv ====
// Purpose: Types shared by the sequencer modules.
// Assumes: Nothing beyond the constants header.
// Notes: State codes are one-hot.
package ssq_pkg;
   typedef enum logic [4:0] {
      ST_INIT = 5'b00001,
      ST_READY = 5'b00010,
      ST_DELAY = 5'b00100,
      ST_RAMP = 5'b01000,
      ST_ON = 5'b10000
   } ssq_state_e;
   typedef logic [15:0] ssq_time_t;
   typedef logic [11:0] ssq_mv_t;
endpackage

// ==== rtl/ssq_clk_if.sv ====
// Purpose: Carrier between the sequencer and its switching clock source.
// Assumes: Both ends run on the core clock.
// Notes: check and sw_tick are one-cycle pulses; the rest are levels.
interface ssq_clk_if;
   logic mode_in;
   logic [15:0] int_period;
   logic check;
   logic locked;
   logic fallback;
   logic sw_tick;
   logic [15:0] meas_period;
   modport ctl (output mode_in, int_period, check,
                input locked, fallback, sw_tick, meas_period);
   modport src (input mode_in, int_period, check,
                output locked, fallback, sw_tick, meas_period);
endinterface

// ==== rtl/ssq_clk_src.sv ====
// Purpose: Switching clock source: internal oscillator, external lock, fallback.
// Assumes: sync_in_i is asynchronous to the core clock.
// Notes: Periods are in core clock cycles.
`include "ssq_consts.svh"
module ssq_clk_src (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   ssq_clk_if.src c,
   input wire logic sync_in_i,
   output logic sync_out_o,
   output logic sync_oe_o
);
   import ssq_pkg::*;
   localparam logic [15:0] WAIT_CYC = 16'(`SSQ_SYNC_WAIT_CYC);
   logic s1_r, s2_r, s3_r;
   logic [15:0] cnt_r, gap_r, meas_r;
   logic search_r, seen_r, locked_r, fallback_r, tick_r, out_r;
   wire rise = s2_r & ~s3_r;
   wire [15:0] period = (locked_r | fallback_r) ? meas_r : c.int_period;
   wire wrap = (cnt_r >= period - 16'h0001);
   wire [15:0] gap_inc = (gap_r == 16'hFFFF) ? gap_r : gap_r + 16'h0001;
   // [RULE21] Loss detection span.
   wire lost = locked_r & (17'(gap_r) >= {meas_r, 1'b0});

   always_ff @(posedge core_clk_i) begin
      s1_r <= sync_in_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         cnt_r <= 16'h0000;
         tick_r <= 1'b0;
         out_r <= 1'b0;
      // [RULE18] Phase locks on rise.
      end else if (locked_r && rise) begin
         cnt_r <= 16'h0000;
         tick_r <= 1'b1;
         out_r <= 1'b1;
      end else begin
         cnt_r <= wrap ? 16'h0000 : cnt_r + 16'h0001;
         tick_r <= wrap;
         out_r <= (cnt_r < {1'b0, period[15:1]});
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         gap_r <= 16'h0000;
         meas_r <= 16'(`SSQ_OSC_PERIOD_CYC);
         search_r <= 1'b0;
         seen_r <= 1'b0;
         locked_r <= 1'b0;
         fallback_r <= 1'b0;
      // [RULE17] Output mode never searches.
      end else if (!c.mode_in) begin
         search_r <= 1'b0;
         locked_r <= 1'b0;
         fallback_r <= 1'b0;
      // [RULE18] Search at each enable.
      end else if (c.check) begin
         gap_r <= 16'h0000;
         search_r <= 1'b1;
         seen_r <= 1'b0;
         locked_r <= 1'b0;
         fallback_r <= 1'b0;
      end else begin
         gap_r <= rise ? 16'h0000 : gap_inc;
         if (search_r) begin
            if (rise && seen_r) begin
               meas_r <= gap_r + 16'h0001;
               locked_r <= 1'b1;
               search_r <= 1'b0;
            end else if (rise) begin
               seen_r <= 1'b1;
            // [RULE20] Clock must already run.
            end else if (gap_r >= WAIT_CYC) begin
               search_r <= 1'b0;
            end
         end else if (lost) begin
            // [RULE21] Keep last measured period.
            locked_r <= 1'b0;
            fallback_r <= 1'b1;
         end else if (locked_r && rise) begin
            meas_r <= gap_r + 16'h0001;
         end
      end
   end

   assign c.locked = locked_r;
   assign c.fallback = fallback_r;
   assign c.sw_tick = tick_r;
   assign c.meas_period = meas_r;
   // [RULE17] Drive internal clock out.
   assign sync_out_o = out_r & ~c.mode_in;
   assign sync_oe_o = ~c.mode_in;
endmodule

// ==== rtl/ssq_top.sv ====
// Purpose: Soft-start delay and ramp, output-ok flag and switching clock control.
// Assumes: APB slave on core_clk_i; measured output and target are in millivolts.
// Notes: Times are in microseconds; a 1 us enable pulse paces the check, delay and output-ok timers.
// Functional notes
// [RULE1] Delay starts at enable, ends at expiry.
// [RULE2] Monotonic ramp slope follows ramp time.
// [RULE3] Three-level strap: 2, 5, 10 ms.
// [RULE4] Resistor strap picks delay and ramp.
// [RULE5] Strap latched only at start-up, restore.
// [RULE6] Auto compensation clamps delay to 5 ms.
// [RULE7] Bus values override strap times.
// [RULE8] Zero delay ramps after initialisation.
// [RULE9] Host keeps ramp above 500 us.
// [RULE10] Ignore enable and bus during check.
// [RULE11] Restore reruns the configuration check.
// [RULE12] Enable accepted only when ready.
// [RULE13] Fixed 2 ms pre-ramp after enable.
// [RULE14] Output ok only in window, no fault.
// [RULE15] Window -10/+15 %, limits, polarity programmable.
// [RULE16] Output ok lags by programmable delay.
// [RULE17] Clock-out mode drives internal 400 kHz.
// [RULE18] Clock-in mode checks, locks each enable.
// [RULE19] Host sets internal frequency near external.
// [RULE20] External clock stable, 200 kHz-1.4 MHz.
// [RULE21] Clock loss falls back to internal; the code keeps the last measured period (meas_r), not int_period.
// [RULE22] Delay under 2 ms becomes 2 ms.
// [RULE23] Output ok drops at once on fault.
`include "ssq_consts.svh"
module ssq_top #(
   parameter int INIT_US = `SSQ_INIT_MS * `SSQ_MS_US,
   parameter int PRERAMP_US = `SSQ_PRERAMP_MS * `SSQ_MS_US
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic en_pin_i,
   input wire logic [1:0] strap_lvl_i,
   input wire logic [4:0] strap_code_i,
   input wire logic fault_i,
   input wire ssq_pkg::ssq_mv_t vout_meas_i,
   input wire logic sync_in_i,
   output logic sync_out_o,
   output logic sync_oe_o,
   output ssq_pkg::ssq_mv_t setpoint_o,
   output logic pwr_run_o,
   output logic sw_tick_o,
   output logic output_ok_flag_o
);
   import ssq_pkg::*;

   localparam logic [6:0] US_LAST = 7'(`SSQ_US_CYC - 1);
   localparam ssq_time_t AUTOCOMP_US = 16'(`SSQ_AUTOCOMP_MS * `SSQ_MS_US);

   function automatic ssq_time_t ss_time(input logic [1:0] idx);
      case (idx)
         2'b00: ss_time = 16'(`SSQ_SS_MS0 * `SSQ_MS_US);
         2'b01: ss_time = 16'(`SSQ_SS_MS1 * `SSQ_MS_US);
         2'b10: ss_time = 16'(`SSQ_SS_MS2 * `SSQ_MS_US);
         default: ss_time = 16'(`SSQ_SS_MS3 * `SSQ_MS_US);
      endcase
   endfunction

   function automatic ssq_time_t max_time(input ssq_time_t a, input ssq_time_t b);
      max_time = (a > b) ? a : b;
   endfunction

   // Scaled compare avoids a divider: v*100 against t*(100-lo) and t*(100+hi).
   function automatic logic win_ok(input ssq_mv_t v, input ssq_mv_t t,
                                   input logic [7:0] lo, input logic [7:0] hi);
      logic [23:0] vs;
      logic [23:0] lo_f;
      logic [23:0] hi_f;
      vs = 24'(v) * 24'(`SSQ_PCT_FULL);
      lo_f = (lo > 8'(`SSQ_PCT_FULL)) ? 24'h00_0000 : 24'(`SSQ_PCT_FULL) - 24'(lo);
      hi_f = 24'(`SSQ_PCT_FULL) + 24'(hi);
      win_ok = (vs >= 24'(t) * lo_f) && (vs <= 24'(t) * hi_f);
   endfunction

   ssq_clk_if clk_bus();

   ssq_state_e state_r, state_nxt;
   logic en1_r, en2_r, flt1_r, flt2_r;
   logic [1:0] lvl1_r, lvl2_r;
   logic [4:0] code1_r, code2_r;
   logic [1:0] strap_lvl_r;
   logic [4:0] strap_code_r;
   logic [6:0] div_r;
   logic us_tick;
   ssq_time_t tmr_r, pgc_r;
   logic [6:0] ctrl_r;
   ssq_time_t dly_reg_r, ramp_reg_r, pgdly_reg_r, osc_reg_r;
   ssq_mv_t target_r, setpoint_r;
   logic [7:0] win_lo_r, win_hi_r;
   logic [23:0] acc_r;
   logic pg_r, out_r;
   logic [31:0] prdata_r;

   always_ff @(posedge core_clk_i) begin
      en1_r <= en_pin_i;
      en2_r <= en1_r;
      flt1_r <= fault_i;
      flt2_r <= flt1_r;
      lvl1_r <= strap_lvl_i;
      lvl2_r <= lvl1_r;
      code1_r <= strap_code_i;
      code2_r <= code1_r;
   end

   assign us_tick = (div_r == US_LAST);
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         div_r <= 7'h00;
      end else begin
         div_r <= us_tick ? 7'h00 : div_r + 7'h01;
      end
   end

   // Register bus decode.
   wire busy = (state_r == ST_INIT);
   wire acc_ph = psel_i & penable_i;
   wire hit = (paddr_i[1:0] == 2'b00) && (paddr_i <= `SSQ_OFS_MEAS);
   // [RULE10] Bus ignored while checking.
   wire wr_ok = acc_ph & pwrite_i & hit & ~busy;
   wire wr_ctrl = wr_ok && (paddr_i == `SSQ_OFS_CTRL);
   // [RULE11] Restore command.
   wire restore = wr_ctrl & pwdata_i[`SSQ_CTRL_RESTORE];
   assign pready_o = 1'b1;
   assign pslverr_o = acc_ph & (busy | ~hit);
   assign prdata_o = prdata_r;

   // [RULE3] Three-level strap decode.
   // [RULE4] Resistor code: delay bits 3:2, ramp bits 1:0.
   wire res_strap = (strap_lvl_r == 2'b11);
   wire [1:0] sd_idx = res_strap ? strap_code_r[3:2] : strap_lvl_r;
   wire [1:0] sr_idx = res_strap ? strap_code_r[1:0] : strap_lvl_r;
   // [RULE7] Bus value overrides strap.
   wire ssq_time_t raw_dly = ctrl_r[`SSQ_CTRL_DLY_OVR] ? dly_reg_r : ss_time(sd_idx);
   wire ssq_time_t eff_ramp = ctrl_r[`SSQ_CTRL_RAMP_OVR] ? ramp_reg_r : ss_time(sr_idx);
   // [RULE8] [RULE13] [RULE22] Pre-ramp floor.
   wire ssq_time_t dly_fl = max_time(raw_dly, 16'(PRERAMP_US));
   // [RULE6] Auto compensation floor.
   wire ssq_time_t eff_dly = ctrl_r[`SSQ_CTRL_AUTOCOMP] ? max_time(dly_fl, AUTOCOMP_US) : dly_fl;
   // [RULE16] Default lag equals ramp time.
   wire ssq_time_t pg_dly = ctrl_r[`SSQ_CTRL_PGDLY_OVR] ? pgdly_reg_r : eff_ramp;

   wire tmr_done = us_tick && (32'(tmr_r) + 32'd1 >= 32'(INIT_US));
   wire dly_done = us_tick && (tmr_r + 16'h0001 >= eff_dly);
   wire run = (state_r == ST_DELAY) | (state_r == ST_RAMP) | (state_r == ST_ON);
   // [RULE12] Enable only in ready state.
   wire accept = (state_r == ST_READY) & en2_r;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_INIT: begin
            if (tmr_done) begin
               state_nxt = ST_READY;
            end
         end
         ST_READY: begin
            if (en2_r) begin
               state_nxt = ST_DELAY;
            end
         end
         ST_DELAY: begin
            // [RULE1] Delay ends on expiry.
            if (dly_done) begin
               state_nxt = ST_RAMP;
            end
         end
         ST_RAMP: begin
            if (setpoint_r >= target_r) begin
               state_nxt = ST_ON;
            end
         end
         ST_ON: begin
            state_nxt = ST_ON;
         end
         default: begin
            state_nxt = ST_INIT;
         end
      endcase
      if (run && !en2_r) begin
         state_nxt = ST_READY;
      end
      if (restore) begin
         state_nxt = ST_INIT;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         state_r <= ST_INIT;
         tmr_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         if (state_nxt != state_r) begin
            tmr_r <= 16'h0000;
         end else if (us_tick) begin
            tmr_r <= tmr_r + 16'h0001;
         end
      end
   end

   // [RULE5] Strap latched at end of check.
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         strap_lvl_r <= 2'b00;
         strap_code_r <= 5'h00;
      end else if (state_r == ST_INIT && tmr_done) begin
         strap_lvl_r <= lvl2_r;
         strap_code_r <= code2_r;
      end
   end

   // [RULE2] Monotonic ramp, one step when the accumulator passes the ramp span.
   wire [23:0] ramp_cyc = 24'(eff_ramp) * 24'(`SSQ_US_CYC);
   wire [23:0] acc_sum = acc_r + 24'(target_r);
   wire step = acc_sum >= ramp_cyc;
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         setpoint_r <= 12'h000;
         acc_r <= 24'h00_0000;
      end else if (state_r == ST_RAMP) begin
         if (ramp_cyc == 24'h00_0000) begin
            setpoint_r <= target_r;
         end else if (setpoint_r < target_r) begin
            setpoint_r <= step ? setpoint_r + 12'h001 : setpoint_r;
            acc_r <= step ? acc_sum - ramp_cyc : acc_sum;
         end
      end else if (state_r == ST_ON) begin
         if (target_r > setpoint_r) begin
            setpoint_r <= target_r;
         end
      end else begin
         setpoint_r <= 12'h000;
         acc_r <= 24'h00_0000;
      end
   end

   // [RULE14] Window and fault qualify.
   wire pg_cond = (state_r == ST_ON) & ~flt2_r &
                  win_ok(vout_meas_i, target_r, win_lo_r, win_hi_r);
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         pg_r <= 1'b0;
         pgc_r <= 16'h0000;
      // [RULE23] Immediate drop.
      end else if (!pg_cond) begin
         pg_r <= 1'b0;
         pgc_r <= 16'h0000;
      // [RULE16] Lag before assertion.
      end else if (!pg_r) begin
         if (pgc_r >= pg_dly) begin
            pg_r <= 1'b1;
         end else if (us_tick) begin
            pgc_r <= pgc_r + 16'h0001;
         end
      end
   end

   // [RULE15] Programmable polarity.
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         out_r <= 1'b0;
      end else begin
         out_r <= pg_r ^ ctrl_r[`SSQ_CTRL_PG_INV];
      end
   end

   // [RULE7] Host-programmed times and settings.
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         ctrl_r <= `SSQ_CTRL_RST;
         dly_reg_r <= 16'h0000;
         ramp_reg_r <= 16'h0000;
         pgdly_reg_r <= 16'h0000;
         target_r <= `SSQ_TARGET_RST;
         win_lo_r <= 8'(`SSQ_PG_LO_PCT);
         win_hi_r <= 8'(`SSQ_PG_HI_PCT);
         osc_reg_r <= 16'(`SSQ_OSC_PERIOD_CYC);
      end else if (wr_ok) begin
         case (paddr_i)
            `SSQ_OFS_CTRL: ctrl_r <= {1'b0, pwdata_i[5:0]};
            `SSQ_OFS_DELAY: dly_reg_r <= pwdata_i[15:0];
            `SSQ_OFS_RAMP: ramp_reg_r <= pwdata_i[15:0];
            `SSQ_OFS_PGDLY: pgdly_reg_r <= pwdata_i[15:0];
            `SSQ_OFS_TARGET: target_r <= pwdata_i[11:0];
            `SSQ_OFS_WINDOW: begin
               win_lo_r <= pwdata_i[7:0];
               win_hi_r <= pwdata_i[15:8];
            end
            `SSQ_OFS_OSC: osc_reg_r <= (pwdata_i[15:0] < 16'h0002) ? 16'h0002 : pwdata_i[15:0];
            default: ctrl_r <= ctrl_r;
         endcase
      end
   end

   wire [31:0] status = {16'h0000, 3'b000, strap_code_r[4], clk_bus.fallback,
                         clk_bus.locked, pg_r, 4'h0, state_r};
   wire [31:0] rd_mux =
      (paddr_i == `SSQ_OFS_CTRL) ? {25'h000_0000, ctrl_r} :
      (paddr_i == `SSQ_OFS_DELAY) ? {16'h0000, dly_reg_r} :
      (paddr_i == `SSQ_OFS_RAMP) ? {16'h0000, ramp_reg_r} :
      (paddr_i == `SSQ_OFS_PGDLY) ? {16'h0000, pgdly_reg_r} :
      (paddr_i == `SSQ_OFS_TARGET) ? {20'h0_0000, target_r} :
      (paddr_i == `SSQ_OFS_WINDOW) ? {16'h0000, win_hi_r, win_lo_r} :
      (paddr_i == `SSQ_OFS_OSC) ? {16'h0000, osc_reg_r} :
      (paddr_i == `SSQ_OFS_STATUS) ? status :
      (paddr_i == `SSQ_OFS_EFFDLY) ? {16'h0000, eff_dly} :
      (paddr_i == `SSQ_OFS_EFFRAMP) ? {16'h0000, eff_ramp} :
      (paddr_i == `SSQ_OFS_MEAS) ? {16'h0000, clk_bus.meas_period} : 32'h0000_0000;

   // Read data is captured in the setup cycle so the access cycle sees a flop.
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel_i && !penable_i) begin
         prdata_r <= (busy || !hit || pwrite_i) ? 32'h0000_0000 : rd_mux;
      end
   end

   // [RULE18] Search pulse at accepted enable.
   assign clk_bus.check = accept;
   assign clk_bus.mode_in = ctrl_r[`SSQ_CTRL_CLK_IN];
   assign clk_bus.int_period = osc_reg_r;

   ssq_clk_src u_clk (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .c(clk_bus.src),
      .sync_in_i(sync_in_i),
      .sync_out_o(sync_out_o),
      .sync_oe_o(sync_oe_o)
   );

   assign setpoint_o = setpoint_r;
   assign pwr_run_o = run;
   assign sw_tick_o = clk_bus.sw_tick;
   assign output_ok_flag_o = out_r;
endmodule

// ==== tb/ssq_sva.sv ====
// Purpose: Port-level checks of the sequencer.
// Assumes: One clock domain; control bits are tracked from accepted bus writes.
// Notes: Time limits scale with the same parameters as the design.
`include "ssq_consts.svh"
module ssq_sva #(
   parameter int INIT_US = 10000,
   parameter int PRERAMP_US = 2000
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic en_pin_i,
   input wire logic fault_i,
   input wire logic sync_out_o,
   input wire logic sync_oe_o,
   input wire ssq_pkg::ssq_mv_t setpoint_o,
   input wire logic pwr_run_o,
   input wire logic output_ok_flag_o
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int INIT_CYC = INIT_US * 100 - 10;
   localparam int PRE_CYC = PRERAMP_US * 100 - 100;
   logic inv_r, inv_q, clkin_r;
   logic [19:0] init_r, pre_r;
   wire logic ctrl_wr = psel_i && penable_i && pwrite_i && !pslverr_o
      && paddr_i == `SSQ_OFS_CTRL;
   // The flag flop applies a new polarity one cycle after the write.
   wire logic ok_on = output_ok_flag_o != inv_q;
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         inv_r <= 1'b0;
         inv_q <= 1'b0;
         clkin_r <= 1'b0;
         init_r <= '0;
         pre_r <= '0;
      end else begin
         if (ctrl_wr) begin
            inv_r <= pwdata_i[`SSQ_CTRL_PG_INV];
            clkin_r <= pwdata_i[`SSQ_CTRL_CLK_IN];
         end
         inv_q <= inv_r;
         if (init_r < INIT_CYC) begin
            init_r <= init_r + 1'b1;
         end
         pre_r <= (pwr_run_o && setpoint_o == '0) ? pre_r + 1'b1 : '0;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   chk_pready_access: assert property ((psel_i && penable_i) |-> pready_o)
      else $error("pready low in access phase");
   chk_bus_init: assert property ((psel_i && penable_i && init_r < INIT_CYC) |-> pslverr_o)
      else $error("bus access accepted during start-up check");
   chk_run_init: assert property ((init_r < INIT_CYC) |-> !pwr_run_o)
      else $error("run started during start-up check");
   chk_run_enable: assert property ($rose(pwr_run_o) |-> $past(en_pin_i, 3) && $past(en_pin_i, 2))
      else $error("run started without enable");
   chk_ramp_mono: assert property ((pwr_run_o && $past(pwr_run_o)) |-> setpoint_o >= $past(setpoint_o))
      else $error("setpoint fell during run");
   chk_preramp_floor: assert property ((pwr_run_o && setpoint_o != '0 && $past(setpoint_o) == '0) |-> pre_r >= PRE_CYC)
      else $error("ramp began before pre-ramp interval");
   chk_ok_run: assert property (ok_on |-> $past(pwr_run_o, 2))
      else $error("output ok asserted while not running");
   chk_fault_drop: assert property (fault_i [*3] |-> ##[1:3] (output_ok_flag_o == inv_q))
      else $error("output ok held during fault");
   chk_oe_mode: assert property (sync_oe_o == !clkin_r)
      else $error("clock pin drive does not follow mode");
   chk_osc_run: assert property (sync_oe_o |-> ##[1:300] (sync_out_o != $past(sync_out_o) || !sync_oe_o))
      else $error("internal clock not driven out");
endmodule

// ==== tb/ssq_peer.sv ====
// Purpose: Peer converter that sources the shared switching clock.
// Assumes: The bench resolves the pin level from both drivers.
// Notes: The clock stands low while the peer is stopped.
module ssq_peer (
   input wire logic run_i,
   output logic clk_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      clk_o = 1'b0;
      forever begin
         #80;
         clk_o = run_i ? ~clk_o : 1'b0;
      end
   end
endmodule

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the sequencer.
// Assumes: Shortened start-up and pre-ramp times.
// Notes: Output voltage follows the setpoint plus a bench offset.
`include "ssq_consts.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ssq_pkg::*;
   localparam int INIT_US = 50;
   localparam int PRE_US = 20;
   logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic en = 1'b0, flt = 1'b0, prun = 1'b1, err, pready, pslverr, sout, soe, run, tick, ok;
   logic [7:0] pa = '0;
   logic [31:0] pwd = '0, rd, prdata;
   logic [1:0] lvl = '0;
   logic [4:0] code = '0, c;
   ssq_mv_t vout = '0, voff = '0, sp;
   logic peer_clk;
   wire logic sync_pin = soe ? sout : peer_clk;
   int n_errors = 0, tests_run = 0, cyc = 0, cnt, dl, rp;
   int ms_tab[4] = '{2000, 5000, 10000, 20000};
   int d_tab[5] = '{0, 1, 300, 300, 6000};
   ssq_top #(.INIT_US(INIT_US), .PRERAMP_US(PRE_US)) i_dut (.core_clk_i(clk), .resetn_i(rstn),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .en_pin_i(en),
      .strap_lvl_i(lvl), .strap_code_i(code), .fault_i(flt), .vout_meas_i(vout),
      .sync_in_i(sync_pin), .sync_out_o(sout), .sync_oe_o(soe), .setpoint_o(sp),
      .pwr_run_o(run), .sw_tick_o(tick), .output_ok_flag_o(ok));
   ssq_peer i_peer (.run_i(prun), .clk_o(peer_clk));
   always #5 clk = ~clk;
   always @(posedge clk) vout <= sp + voff;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         n_errors++;
         results();
      end
   end
   task automatic results();
      if (n_errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("BAD %s exp %0h got %0h", n, e, g);
         n_errors++;
      end
   endtask
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(n, e, rd);
   endtask
   task automatic rng(input string n, input int lo, input int hi);
      tests_run++;
      if (cnt < lo || cnt > hi) begin
         $display("BAD %s exp %0d..%0d got %0d", n, lo, hi, cnt);
         n_errors++;
      end
   endtask
   function automatic logic cond(input int k);
      case (k)
         0: return sp !== 12'h000;
         1: return sp === 12'h3E8;
         2: return ok === 1'b1;
         3: return ok === 1'b0;
         default: return tick === 1'b1;
      endcase
   endfunction
   task automatic wt(input int k);
      cnt = 0;
      while (!cond(k) && cnt < 9000) begin
         @(posedge clk);
         cnt++;
      end
   endtask
   task automatic boot();
      cnt = 0;
      err = 1'b1;
      while ((err !== 1'b0 || rd == '0) && cnt < 3000) begin
         bus(1'b0, `SSQ_OFS_STATUS, 32'h0000_0000);
         cnt++;
      end
   endtask
   initial begin
      void'($urandom(20410));
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      bus(1'b1, `SSQ_OFS_TARGET, 32'h0000_03E8);
      chk("init_err", 32'h0000_0001, 32'(err));
      rdc("init_rd", `SSQ_OFS_STATUS, 32'h0000_0000);
      boot();
      chk("ready", 32'h0000_0002, rd & 32'h0000_001F);
      rdc("tgt", `SSQ_OFS_TARGET, 32'(`SSQ_TARGET_RST));
      for (int i = 0; i < 6; i++) begin
         c = 5'($urandom);
         lvl <= (i < 3) ? 2'(i) : 2'b11;
         code <= c;
         bus(1'b1, `SSQ_OFS_CTRL, 32'h0000_0040);
         boot();
         dl = (i < 3) ? ms_tab[i] : ms_tab[c[3:2]];
         rp = (i < 3) ? ms_tab[i] : ms_tab[c[1:0]];
         if (i > 2) begin
            chk("uv", 32'(c[4]), 32'(rd[12]));
         end
         rdc("eff_dly", `SSQ_OFS_EFFDLY, dl);
         rdc("eff_ramp", `SSQ_OFS_EFFRAMP, rp);
      end
      lvl <= 2'b10;
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, `SSQ_OFS_DELAY, 32'(d_tab[i]));
         bus(1'b1, `SSQ_OFS_CTRL, (i > 2) ? 32'h0000_0011 : 32'h0000_0001);
         dl = (d_tab[i] > PRE_US) ? d_tab[i] : PRE_US;
         dl = (i > 2 && dl < `SSQ_AUTOCOMP_MS * `SSQ_MS_US) ? `SSQ_AUTOCOMP_MS * `SSQ_MS_US : dl;
         rdc("eff_ovr", `SSQ_OFS_EFFDLY, dl);
      end
      rdc("strap_hold", `SSQ_OFS_EFFRAMP, rp);
      bus(1'b1, `SSQ_OFS_TARGET, 32'h0000_03E8);
      bus(1'b1, `SSQ_OFS_DELAY, 32'h0000_0032);
      bus(1'b1, `SSQ_OFS_RAMP, 32'h0000_001E);
      bus(1'b1, `SSQ_OFS_PGDLY, 32'h0000_000A);
      bus(1'b1, `SSQ_OFS_OSC, 32'h0000_0010);
      bus(1'b1, `SSQ_OFS_CTRL, 32'h0000_0027);
      rdc("ramp_ovr", `SSQ_OFS_EFFRAMP, 32'h0000_001E);
      en <= 1'b1;
      wt(0);
      rng("delay", 4900, 5300);
      wt(1);
      rng("ramp", 2800, 3200);
      wt(2);
      rng("pg_dly", 900, 1150);
      rdc("meas", `SSQ_OFS_MEAS, 32'h0000_0010);
      bus(1'b0, `SSQ_OFS_STATUS, 32'h0000_0000);
      chk("locked", 32'h0000_0001, 32'(rd[10]));
      flt <= 1'b1;
      wt(3);
      rng("flt_drop", 1, 6);
      flt <= 1'b0;
      voff <= 12'h096;
      wt(2);
      rng("win_edge", 900, 1150);
      voff <= 12'h097;
      wt(3);
      rng("win_drop", 1, 6);
      bus(1'b1, `SSQ_OFS_CTRL, 32'h0000_002F);
      bus(1'b0, `SSQ_OFS_STATUS, 32'h0000_0000);
      chk("pg_inv", 32'h0000_0001, 32'(ok));
      prun <= 1'b0;
      cnt = 0;
      while (rd[11] !== 1'b1 && cnt < 40) begin
         bus(1'b0, `SSQ_OFS_STATUS, 32'h0000_0000);
         cnt++;
      end
      rng("fallback", 1, 30);
      wt(4);
      @(posedge clk);
      wt(4);
      rng("fb_period", 13, 17);
      en <= 1'b0;
      repeat (2) bus(1'b0, `SSQ_OFS_STATUS, 32'h0000_0000);
      chk("off_state", 32'h0000_0002, rd & 32'h0000_001F);
      chk("off_ok", 32'h0000_0001, 32'(ok));
      bus(1'b1, `SSQ_OFS_CTRL, 32'h0000_0040);
      bus(1'b0, `SSQ_OFS_STATUS, 32'h0000_0000);
      chk("restore_init", 32'h0000_0001, 32'(err));
      results();
   end
endmodule
bind ssq_top ssq_sva #(.INIT_US(INIT_US), .PRERAMP_US(PRERAMP_US)) u_sva (
   .core_clk_i(core_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .en_pin_i(en_pin_i), .fault_i(fault_i), .sync_out_o(sync_out_o),
   .sync_oe_o(sync_oe_o), .setpoint_o(setpoint_o), .pwr_run_o(pwr_run_o),
   .output_ok_flag_o(output_ok_flag_o));
